//--- inc/ssp_pkg.sv
// Purpose: Shared constants for the byte-wide synchronous serial port
// Assumes: Word-per-register Wishbone map, byte address is four times the index
// Notes:   Control bit positions, reset values and clock divisors live here
package ssp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices, byte address is index times four
	localparam logic [7:0] CTRL_IDX     = 8'hc0;
	localparam logic [7:0] BUF_IDX      = 8'hc1;
	localparam logic [7:0] IRQ_STAT_IDX = 8'hd0;
	localparam logic [7:0] IRQ_CLR_IDX  = 8'hd1;
	localparam logic [7:0] IRQ_EN_IDX   = 8'hd2;

	////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int DONE_POS   = 7;
	localparam int REG_ON_POS = 5;
	localparam int RXGO_POS   = 4;
	localparam int RATE_POS   = 3;
	localparam int EDGE_POS   = 2;
	localparam int DIR_POS    = 1;
	localparam int FUNC_POS   = 0;
	localparam logic [7:0] CTRL_WMASK = 8'h3f;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] BUF_RST    = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Interrupt status fields
	localparam int IRQ_TX_POS = 0;
	localparam int IRQ_RX_POS = 1;
	localparam logic [1:0] IRQ_RST = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Serial clock divisors and bit count
	localparam int DIV_FAST = 2;
	localparam int DIV_SLOW = 256;
	localparam logic [6:0] HALF_FAST_M1 = 7'(DIV_FAST / 2 - 1);
	localparam logic [6:0] HALF_SLOW_M1 = 7'(DIV_SLOW / 2 - 1);
	localparam logic [2:0] LAST_BIT     = 3'h7;

endpackage : ssp_pkg

//--- logic/shift_engine.sv
// Purpose: Bit engine, makes or follows the serial clock and shifts one byte
// Assumes: Serial clock and data inputs arrive already synchronised
// Notes:   MSB first, first bit is driven before the first clock edge
`timescale 1ns/100ps
`default_nettype none
module shift_engine
	import ssp_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       start_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic       ext_clk_i,
	input  wire logic       rate_i,
	input  wire logic       edge_i,
	input  wire logic       sclk_in_i,
	input  wire logic       sdata_in_i,
	output logic            sclk_o,
	output logic            sdata_o,
	output logic            busy_o,
	output logic            done_o,
	output logic [7:0]      rx_byte_o
);
	import ssp_pkg::*;

	logic       busy_r, busy_nxt, sclk_r, sclk_nxt, out_r, out_nxt;
	logic       done_r, done_nxt, prev_r;
	logic [7:0] sh_r, sh_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [6:0] div_r, div_nxt;
	logic       tick, rise, fall, latch, launch;

	////////////////////////////////////////////////////////////////////////
	// Edge finding, divider and shift sequence
	always_comb begin
		tick     = (div_r == (rate_i ? HALF_SLOW_M1 : HALF_FAST_M1));
		rise     = ext_clk_i ? (sclk_in_i & ~prev_r) : (tick & ~sclk_r);
		fall     = ext_clk_i ? (~sclk_in_i & prev_r) : (tick & sclk_r);
		latch    = edge_i ? rise : fall;
		launch   = edge_i ? fall : rise;
		busy_nxt = busy_r;
		sclk_nxt = sclk_r;
		out_nxt  = out_r;
		sh_nxt   = sh_r;
		cnt_nxt  = cnt_r;
		div_nxt  = 7'h00;
		done_nxt = 1'b0;
		if (!busy_r) begin
			sclk_nxt = edge_i;
			if (start_i) begin
				busy_nxt = 1'b1;
				sh_nxt   = tx_byte_i;
				out_nxt  = tx_byte_i[7];
				cnt_nxt  = 3'h0;
			end
		end else begin
			div_nxt = tick ? 7'h00 : div_r + 7'h01;
			if (!ext_clk_i && tick) begin
				sclk_nxt = ~sclk_r;
			end
			if (latch) begin
				sh_nxt  = {sh_r[6:0], sdata_in_i};
				cnt_nxt = cnt_r + 3'h1;
				if (cnt_r == LAST_BIT) begin
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
				end
			end
			if (launch && cnt_r != 3'h0) begin
				out_nxt = sh_r[7];
			end
		end
	end

	// Engine state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			sclk_r <= 1'b0;
			out_r  <= 1'b0;
			done_r <= 1'b0;
			prev_r <= 1'b0;
			sh_r   <= 8'h00;
			cnt_r  <= 3'h0;
			div_r  <= 7'h00;
		end else begin
			busy_r <= busy_nxt;
			sclk_r <= sclk_nxt;
			out_r  <= out_nxt;
			done_r <= done_nxt;
			prev_r <= sclk_in_i;
			sh_r   <= sh_nxt;
			cnt_r  <= cnt_nxt;
			div_r  <= div_nxt;
		end
	end

	assign sclk_o    = sclk_r;
	assign sdata_o   = out_r;
	assign busy_o    = busy_r;
	assign done_o    = done_r;
	assign rx_byte_o = sh_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_fast_clock_toggle: assert property (busy_r && $past(busy_r) && !ext_clk_i && !rate_i
		&& $stable(rate_i) && $past(!ext_clk_i) |-> $changed(sclk_r))
		else $error("fast serial clock did not toggle every cycle");
	a_slow_clock_hold: assert property ($changed(sclk_r) && busy_r && !ext_clk_i && rate_i
		&& $past(busy_r) ##1 rate_i |-> $stable(sclk_r)[*8])
		else $error("slow serial clock toggled too early");
	a_idle_clock_level: assert property (!busy_r && !$past(busy_r) && $stable(edge_i)
		|-> sclk_r == edge_i)
		else $error("serial clock not at idle level");
	a_done_ends_busy: assert property (done_r |-> !busy_r && $past(busy_r))
		else $error("done without a finished transfer");

endmodule : shift_engine
`default_nettype wire

//--- logic/sync_serial_port_byte.sv
// Purpose: Byte-wide synchronous serial port with Wishbone register access
// Assumes: Classic Wishbone slave, 32-bit data, byte lane 0 carries the registers
// Notes:   Pins are split into input, output and output enable
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Completion flag set by hardware after all eight bits shifted.
// - Entering interrupt service clears completion flag; software may clear it too.
// - Receive enable bit written from zero to one starts one byte receive.
// - Generated clock runs at oscillator over 2, or over 256 when selected.
// - Edge select 0 latches on falling, idle low; 1 rising, idle high.
// - Clock direction 0 drives clock pin out; 1 takes it as input.
// - Function select 0 leaves pins as plain I/O; 1 gives them to port.
// - Buffer address: reads return receive register, writes load transmit buffer.
// - Control register holds regulator on bit, exported as control output.
// - Control register resets to zero: plain I/O, clock as output.
module sync_serial_port_byte
	import ssp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        intr_ack_i,
	output logic             irq_o,
	output logic             reg_on_o,
	input  wire logic        clk_pin_i,
	output logic             clk_pin_o,
	output logic             clk_pin_oe_o,
	input  wire logic        data_pin_i,
	output logic             data_pin_o,
	output logic             data_pin_oe_o,
	input  wire logic        gpio_clk_out_i,
	input  wire logic        gpio_clk_oe_i,
	input  wire logic        gpio_data_out_i,
	input  wire logic        gpio_data_oe_i,
	output logic             gpio_clk_in_o,
	output logic             gpio_data_in_o
);
	import ssp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]  ctrl_r, ctrl_nxt;
	logic [7:0]  txbuf_r, txbuf_nxt;
	logic [7:0]  rx_r, rx_nxt;
	logic [1:0]  irq_st_r, irq_st_nxt;
	logic [1:0]  irq_en_r, irq_en_nxt;
	logic        ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic        irq_r, irq_nxt;
	logic        tx_mode_r, tx_mode_nxt;
	logic        clk_o_r, clk_o_nxt, clk_oe_r, clk_oe_nxt;
	logic        dat_o_r, dat_o_nxt, dat_oe_r, dat_oe_nxt;
	logic        clk_s1_r, clk_s2_r, dat_s1_r, dat_s2_r;
	logic        acc, wr, rd;
	logic [9:0]  widx;
	logic        rx_go, tx_go, start;
	logic        eng_sclk, eng_sdata, eng_busy, eng_done;
	logic [7:0]  eng_rx;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, two flops before any logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			dat_s1_r <= 1'b0;
			dat_s2_r <= 1'b0;
		end else begin
			clk_s1_r <= clk_pin_i;
			clk_s2_r <= clk_s1_r;
			dat_s1_r <= data_pin_i;
			dat_s2_r <= dat_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit engine
	shift_engine u_engine (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.start_i    (start),
		.tx_byte_i  (txbuf_nxt),
		.ext_clk_i  (ctrl_r[DIR_POS]),
		.rate_i     (ctrl_r[RATE_POS]),
		.edge_i     (ctrl_r[EDGE_POS]),
		.sclk_in_i  (clk_s2_r),
		.sdata_in_i (dat_s2_r),
		.sclk_o     (eng_sclk),
		.sdata_o    (eng_sdata),
		.busy_o     (eng_busy),
		.done_o     (eng_done),
		.rx_byte_o  (eng_rx)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign widx = wb_adr_i[11:2];
	assign acc  = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr   = acc & wb_we_i & wb_sel_i[0];
	assign rd   = acc & ~wb_we_i;

	// Transfer starts, a busy engine ignores new starts
	assign rx_go = wr && widx == {2'b00, CTRL_IDX} && wb_dat_i[RXGO_POS]
		&& !ctrl_r[RXGO_POS] && ctrl_r[FUNC_POS];
	assign tx_go = wr && widx == {2'b00, BUF_IDX} && ctrl_r[FUNC_POS];
	assign start = (rx_go | tx_go) & ~eng_busy;

	////////////////////////////////////////////////////////////////////////
	// Register file, completion flag and interrupts
	always_comb begin
		ctrl_nxt    = ctrl_r;
		txbuf_nxt   = txbuf_r;
		rx_nxt      = rx_r;
		irq_st_nxt  = irq_st_r;
		irq_en_nxt  = irq_en_r;
		tx_mode_nxt = tx_mode_r;
		ack_nxt     = acc;
		dat_nxt     = 32'h0000_0000;
		// Register writes
		if (wr) begin
			case (widx)
				{2'b00, CTRL_IDX}: begin
					ctrl_nxt[5:0]    = wb_dat_i[5:0] & CTRL_WMASK[5:0];
					ctrl_nxt[DONE_POS] = ctrl_r[DONE_POS] & wb_dat_i[DONE_POS];
				end
				{2'b00, BUF_IDX}:     txbuf_nxt = wb_dat_i[7:0];
				{2'b00, IRQ_CLR_IDX}: irq_st_nxt = irq_st_r & ~wb_dat_i[1:0];
				{2'b00, IRQ_EN_IDX}:  irq_en_nxt = wb_dat_i[1:0];
				default: ;
			endcase
		end
		// Mode of the transfer being started
		if (start) begin
			tx_mode_nxt = tx_go;
		end
		// Entering interrupt service clears the flag
		if (intr_ack_i) begin
			ctrl_nxt[DONE_POS] = 1'b0;
		end
		// End of byte: set wins over any clear in the same cycle
		if (eng_done) begin
			ctrl_nxt[DONE_POS] = 1'b1;
			rx_nxt = eng_rx;
			if (tx_mode_r) begin
				irq_st_nxt[IRQ_TX_POS] = 1'b1;
			end else begin
				irq_st_nxt[IRQ_RX_POS] = 1'b1;
			end
		end
		// Read data, unmapped reads as zero
		if (rd) begin
			case (widx)
				{2'b00, CTRL_IDX}:     dat_nxt = {24'h00_0000, ctrl_r};
				{2'b00, BUF_IDX}:      dat_nxt = {24'h00_0000, rx_r};
				{2'b00, IRQ_STAT_IDX}: dat_nxt = {30'h0000_0000, irq_st_r};
				{2'b00, IRQ_EN_IDX}:   dat_nxt = {30'h0000_0000, irq_en_r};
				default:               dat_nxt = 32'h0000_0000;
			endcase
		end
		irq_nxt = |(irq_st_r & irq_en_r);
	end

	// Register state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r    <= CTRL_RST;
			txbuf_r   <= BUF_RST;
			rx_r      <= BUF_RST;
			irq_st_r  <= IRQ_RST;
			irq_en_r  <= IRQ_RST;
			tx_mode_r <= 1'b0;
			ack_r     <= 1'b0;
			dat_r     <= 32'h0000_0000;
			irq_r     <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			txbuf_r   <= txbuf_nxt;
			rx_r      <= rx_nxt;
			irq_st_r  <= irq_st_nxt;
			irq_en_r  <= irq_en_nxt;
			tx_mode_r <= tx_mode_nxt;
			ack_r     <= ack_nxt;
			dat_r     <= dat_nxt;
			irq_r     <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin multiplexing between port and plain I/O
	always_comb begin
		if (ctrl_r[FUNC_POS]) begin
			clk_o_nxt  = eng_sclk;
			clk_oe_nxt = ~ctrl_r[DIR_POS];
			dat_o_nxt  = eng_sdata;
			dat_oe_nxt = tx_mode_r;
		end else begin
			clk_o_nxt  = gpio_clk_out_i;
			clk_oe_nxt = gpio_clk_oe_i;
			dat_o_nxt  = gpio_data_out_i;
			dat_oe_nxt = gpio_data_oe_i;
		end
	end

	// Pin output flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_o_r  <= 1'b0;
			clk_oe_r <= 1'b0;
			dat_o_r  <= 1'b0;
			dat_oe_r <= 1'b0;
		end else begin
			clk_o_r  <= clk_o_nxt;
			clk_oe_r <= clk_oe_nxt;
			dat_o_r  <= dat_o_nxt;
			dat_oe_r <= dat_oe_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_dat_o       = dat_r;
	assign wb_ack_o       = ack_r;
	assign irq_o          = irq_r;
	assign reg_on_o       = ctrl_r[REG_ON_POS];
	assign clk_pin_o      = clk_o_r;
	assign clk_pin_oe_o   = clk_oe_r;
	assign data_pin_o     = dat_o_r;
	assign data_pin_oe_o  = dat_oe_r;
	assign gpio_clk_in_o  = clk_s2_r;
	assign gpio_data_in_o = dat_s2_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_done_sets_flag: assert property (eng_done |=> ctrl_r[DONE_POS])
		else $error("completion flag not set after byte");
	a_service_clears: assert property (intr_ack_i && !eng_done |=> !ctrl_r[DONE_POS])
		else $error("completion flag not cleared on service");
	a_rx_start_busy: assert property (rx_go && !eng_busy |=> eng_busy ##1 !tx_mode_r)
		else $error("receive start did not begin a transfer");
	a_clock_direction: assert property ($past(ctrl_r[FUNC_POS])
		|-> clk_oe_r == !$past(ctrl_r[DIR_POS]))
		else $error("clock pin direction wrong");
	a_plain_io_pass: assert property ($past(!ctrl_r[FUNC_POS])
		|-> clk_o_r == $past(gpio_clk_out_i) && dat_oe_r == $past(gpio_data_oe_i))
		else $error("plain I/O not passed through");
	a_buf_read_rx: assert property (rd && widx == {2'b00, BUF_IDX}
		|=> wb_ack_o && wb_dat_o[7:0] == $past(rx_r))
		else $error("buffer read did not return receive register");
	a_regulator_out: assert property (wr && widx == {2'b00, CTRL_IDX}
		|=> reg_on_o == $past(wb_dat_i[REG_ON_POS]))
		else $error("regulator output not following control write");
	a_reset_ctrl_zero: assert property ($past(rst_i) |-> ctrl_r == 8'h00 && !clk_oe_r)
		else $error("control register not zero after reset");
	a_tx_write_start: assert property (tx_go && !eng_busy |=> eng_busy && tx_mode_r ##1 data_pin_oe_o)
		else $error("transmit write did not start a transfer");
	a_irq_level: assert property (irq_o == $past(|(irq_st_r & irq_en_r)))
		else $error("interrupt output wrong");

	c_tx_done: cover property (eng_done && tx_mode_r);
	c_rx_done: cover property (eng_done && !tx_mode_r);
	c_irq_raised: cover property ($rose(irq_o));
	c_set_and_clear: cover property (eng_done && intr_ack_i);

endmodule : sync_serial_port_byte
`default_nettype wire

//--- verif/serial_peer.sv
// Purpose: Far-side serial peer that captures, sends and can make the clock
// Assumes: Pins are resolved in the bench with pull-ups when released
// Notes:   Latch and launch edges follow the edge select input
`timescale 1ns/100ps
`default_nettype none
module serial_peer #(
	parameter int HALF = 8
) (
	input  wire logic       clk_i,
	input  wire logic       sclk_i,
	input  wire logic       sdat_i,
	input  wire logic       edge_i,
	input  wire logic       ext_i,
	input  wire logic       go_i,
	input  wire logic       load_i,
	input  wire logic       drive_i,
	input  wire logic [7:0] send_i,
	output logic            sclk_o = 1'b0,
	output logic            sclk_en_o,
	output logic            sdat_o,
	output logic            sdat_en_o,
	output logic [7:0]      cap_o = 8'h00,
	output logic [15:0]     ivl_o = 16'h0000
);
	logic        prev = 1'b0;
	logic [7:0]  sr   = 8'h00;
	logic [3:0]  nlat = 4'h0;
	logic [15:0] cnt  = 16'h0000;
	logic [4:0]  tog  = 5'h00;
	logic [7:0]  hc   = 8'h00;
	logic        latch;
	logic        launch;

	// Edge kinds seen on the wire
	assign latch     = (sclk_i != prev) && (sclk_i == edge_i);
	assign launch    = (sclk_i != prev) && (sclk_i != edge_i);
	assign sclk_en_o = ext_i;
	assign sdat_en_o = drive_i;
	assign sdat_o    = sr[7];

	// Capture on latch edges, shift out after the first bit has been latched
	always @(posedge clk_i) begin
		prev <= sclk_i;
		cnt  <= (latch || launch) ? 16'h0000 : cnt + 16'h0001;
		if (latch || launch) ivl_o <= cnt + 16'h0001;
		if (load_i) begin
			sr   <= send_i;
			nlat <= 4'h0;
		end else if (latch) begin
			cap_o <= {cap_o[6:0], sdat_i};
			nlat  <= nlat + 4'h1;
		end else if (launch && nlat != 4'h0) begin
			sr <= {sr[6:0], ~sr[0]};
		end
	end

	// Clock maker: sixteen toggles, idle at the edge select level
	always @(posedge clk_i) begin
		if (go_i) begin
			tog <= 5'h10;
			hc  <= 8'h00;
		end else if (tog != 5'h00 && hc == 8'(HALF - 1)) begin
			hc     <= 8'h00;
			tog    <= tog - 5'h01;
			sclk_o <= ~sclk_o;
		end else if (tog != 5'h00) begin
			hc <= hc + 8'h01;
		end else begin
			sclk_o <= edge_i;
		end
	end
endmodule : serial_peer
`default_nettype wire

//--- verif/testbench.sv
// Purpose: Register-level bench for the byte serial port
// Assumes: Classic Wishbone master, one idle cycle between accesses
// Notes:   Port pins have pull-ups when nobody drives them
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ssp_pkg::*;
	localparam logic [11:0] CTRL_A = {2'b00, CTRL_IDX, 2'b00};
	localparam logic [11:0] BUF_A  = {2'b00, BUF_IDX, 2'b00};
	localparam logic [11:0] ST_A   = {2'b00, IRQ_STAT_IDX, 2'b00};
	localparam logic [11:0] CLR_A  = {2'b00, IRQ_CLR_IDX, 2'b00};
	localparam logic [11:0] EN_A   = {2'b00, IRQ_EN_IDX, 2'b00};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, iack = 1'b0;
	logic [3:0]  sel = 4'h0, lane = 4'hf;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, irq, reg_on, c_o, c_oe, d_o, d_oe, gc_in, gd_in;
	logic        g_co = 1'b0, g_coe = 1'b0, g_do = 1'b0, g_doe = 1'b0;
	logic        p_edge = 1'b0, p_ext = 1'b0, p_go = 1'b0, p_load = 1'b0, p_drive = 1'b0;
	logic [7:0]  p_send = 8'h00, p_cap, q;
	logic [15:0] p_ivl;
	logic        p_c, p_cen, p_d, p_den, clk_w, dat_w;
	int          err_total = 0, num_checks = 0, cycles = 0;

	// Pin levels, pull-up when released
	assign clk_w = c_oe ? c_o : (p_cen ? p_c : 1'b1);
	assign dat_w = d_oe ? d_o : (p_den ? p_d : 1'b1);

	sync_serial_port_byte dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .intr_ack_i(iack),
		.irq_o(irq), .reg_on_o(reg_on), .clk_pin_i(clk_w), .clk_pin_o(c_o), .clk_pin_oe_o(c_oe),
		.data_pin_i(dat_w), .data_pin_o(d_o), .data_pin_oe_o(d_oe), .gpio_clk_out_i(g_co),
		.gpio_clk_oe_i(g_coe), .gpio_data_out_i(g_do), .gpio_data_oe_i(g_doe), .gpio_clk_in_o(gc_in),
		.gpio_data_in_o(gd_in));
	serial_peer #(.HALF(8)) peer (.clk_i(clk_i), .sclk_i(clk_w), .sdat_i(dat_w), .edge_i(p_edge), .ext_i(p_ext),
		.go_i(p_go), .load_i(p_load), .drive_i(p_drive), .send_i(p_send), .sclk_o(p_c), .sclk_en_o(p_cen),
		.sdat_o(p_d), .sdat_en_o(p_den), .cap_o(p_cap), .ivl_o(p_ivl));

	// Clock and hang guard
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One classic cycle, held until ack is sampled high
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= lane;
		wdat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		sel <= 4'h0;
	endtask : bus

	task automatic rd(input string what, input logic [11:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(what, {24'h0, q}, {24'h0, exp});
	endtask : rd

	task automatic wait_done();
		q = 8'h00;
		while (q[7] !== 1'b1) bus(1'b0, CTRL_A, 8'h00);
	endtask : wait_done

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("ctrl reset", CTRL_A, 8'h00);
		rd("buf reset", BUF_A, 8'h00);
		check("clk oe reset", c_oe, 1'b0);
		bus(1'b1, CTRL_A, 8'h60);
		check("regulator", reg_on, 1'b1);
		rd("ctrl reserved", CTRL_A, 8'h20);
		g_co  <= 1'b1;
		g_coe <= 1'b1;
		g_doe <= 1'b1;
		repeat (5) @(posedge clk_i);
		check("gpio pins", {c_oe, c_o, d_oe, d_o, gc_in, gd_in}, 6'b111010);
		g_coe <= 1'b0;
		g_doe <= 1'b0;
		bus(1'b1, EN_A, 8'h01);
		bus(1'b1, CTRL_A, 8'h01);
		repeat (2) @(posedge clk_i);
		check("clk out idle low", {c_oe, c_o}, 2'b10);
		bus(1'b1, BUF_A, 8'ha5);
		wait_done();
		check("tx byte fast", p_cap, 8'ha5);
		check("fast half period", p_ivl, 16'd1);
		check("irq tx", irq, 1'b1);
		rd("status tx", ST_A, 8'h01);
		bus(1'b1, CLR_A, 8'h01);
		rd("status cleared", ST_A, 8'h00);
		check("irq cleared", irq, 1'b0);
		bus(1'b1, CTRL_A, 8'h01);
		rd("flag sw clear", CTRL_A, 8'h01);
		bus(1'b1, CTRL_A, 8'h0d);
		p_edge <= 1'b1;
		repeat (2) @(posedge clk_i);
		check("idle high", clk_w, 1'b1);
		bus(1'b1, BUF_A, 8'h5a);
		wait_done();
		check("tx byte slow", p_cap, 8'h5a);
		check("slow half period", p_ivl, 16'd128);
		iack <= 1'b1;
		@(posedge clk_i);
		iack <= 1'b0;
		rd("flag isr clear", CTRL_A, 8'h0d);
		bus(1'b1, CLR_A, 8'h01);
		p_send  <= 8'h3c;
		p_load  <= 1'b1;
		p_drive <= 1'b1;
		@(posedge clk_i);
		p_load <= 1'b0;
		bus(1'b1, CTRL_A, 8'h1d);
		@(posedge clk_i);
		check("rx data released", d_oe, 1'b0);
		wait_done();
		rd("rx byte", BUF_A, 8'h3c);
		rd("status rx", ST_A, 8'h02);
		check("irq masked", irq, 1'b0);
		bus(1'b1, EN_A, 8'h02);
		repeat (2) @(posedge clk_i);
		check("irq rx", irq, 1'b1);
		bus(1'b1, CLR_A, 8'h02);
		p_edge <= 1'b0;
		p_ext  <= 1'b1;
		bus(1'b1, CTRL_A, 8'h03);
		repeat (2) @(posedge clk_i);
		check("clk input", c_oe, 1'b0);
		p_send <= 8'hc3;
		p_load <= 1'b1;
		@(posedge clk_i);
		p_load <= 1'b0;
		bus(1'b1, CTRL_A, 8'h13);
		p_go <= 1'b1;
		@(posedge clk_i);
		p_go <= 1'b0;
		wait_done();
		rd("rx ext clock", BUF_A, 8'hc3);
		rd("unmapped", 12'h3fc, 8'h00);
		rd("clear reads zero", CLR_A, 8'h00);
		// A write without byte lane 0 is acked but leaves the control register alone
		lane = 4'he;
		bus(1'b1, CTRL_A, 8'h00);
		lane = 4'hf;
		rd("lane 0 off write ignored", CTRL_A, 8'h93);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
